// ---- logic/rsm_unit.sv ----
// Right shift, signed multiply-accumulate, short jump and skip datapath
// How it works
// - Shift count is immediate 0..15 or register (10h..FFh) value 0..31.
// - Arithmetic right shifts fill vacated top bits with the original sign.
// - Logical right shifts fill vacated top bits with zeros.
// - Each step copies the operand low bit into carry.
// - Every right shift clears the residue flag at start.
// - Residue sets when a one sits in carry and another step follows.
// - Byte arithmetic shift is 1Ah, byte logical shift is 18h.
// - Long arithmetic shift is 0Eh, long logical shift is 0Ch.
// - Displacement extends to 16 bits small mode, 24 bits large mode.
// - Opcode 00h is a two-byte no-op changing no flags.
// - Signed word product adds into the 40-bit accumulator.
// - Zeroing variants load the accumulator with the sign-extended product.
// - Opcodes 011011aa and 010011aa; selector 01, 05, 09, 0D picks variant.
// - Relocating variants write the memory operand to its address plus 2.
// - Relocating variants refuse immediate addressing.
`timescale 1ns/100ps
`default_nettype none
module rsm_unit
  import rsm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Decoder request
  input wire logic start_i,
  input wire rsm_instr_t instr_i,
  input wire logic carry_i,
  // Results
  output logic busy_o,
  output logic done_o,
  output rsm_result_t res_o
);
  typedef struct packed {
    rsm_state_t state;
    logic [4:0] count;
    logic [1:0] size;
    logic arith;
    logic sign;
    logic busy;
    logic reloc_pend;
    logic jump_pend;
    logic done;
    rsm_result_t res;
  } rsm_regs_t;

  rsm_regs_t st_r;
  rsm_regs_t st_nxt;

  // Operand size codes, as the step module decodes them
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  // Count end points
  localparam logic [4:0] CNT_NONE = 5'h00;
  localparam logic [4:0] CNT_LAST = 5'h01;

  logic [31:0] step_val;
  logic step_carry;
  logic step_res;
  logic [31:0] product;
  logic [RSM_ACC_W-1:0] product_ext;
  logic [23:0] disp_ext;
  logic [4:0] cnt_sel;
  logic is_shift;
  logic is_mac;
  logic is_jump;
  logic sel_zero;
  logic sel_reloc;
  logic sel_known;
  logic aa_imm;

  rsm_shift_step u_step (
    .val_i(st_r.res.result),
    .size_i(st_r.size),
    .arith_i(st_r.arith),
    .sign_i(st_r.sign),
    .carry_i(st_r.res.carry),
    .residue_i(st_r.res.residue_flag),
    .val_o(step_val),
    .carry_o(step_carry),
    .residue_o(step_res)
  );

  // Decode of the request; only read on the take edge
  always_comb begin
    product = 32'($signed(instr_i.src1) * $signed(instr_i.src2));
    product_ext = {{(RSM_ACC_W-32){product[31]}}, product};
    disp_ext = {{13{instr_i.disp[10]}}, instr_i.disp};
    // Register counts use five bits, immediates four
    if (instr_i.count_is_reg)
      cnt_sel = instr_i.count_reg_val[4:0] & RSM_REG_CNT_MASK;
    else
      cnt_sel = instr_i.count_byte[4:0] & RSM_IMM_CNT_MASK;
    is_shift = (instr_i.opcode == RSM_OP_ARITH_RIGHT_BYTE) ||
               (instr_i.opcode == RSM_OP_LOGIC_RIGHT_BYTE) ||
               (instr_i.opcode == RSM_OP_ARITH_RIGHT_WORD) ||
               (instr_i.opcode == RSM_OP_LOGIC_RIGHT_WORD) ||
               (instr_i.opcode == RSM_OP_ARITH_RIGHT_LONG) ||
               (instr_i.opcode == RSM_OP_LOGIC_RIGHT_LONG);
    is_mac = (instr_i.opcode[7:2] == RSM_OP_MAC2_HI) ||
             (instr_i.opcode[7:2] == RSM_OP_MAC3_HI);
    is_jump = (instr_i.opcode[7:3] == RSM_OP_SHORT_RELATIVE_JUMP_HI);
    sel_zero = (instr_i.selector == RSM_SEL_ZERO) ||
               (instr_i.selector == RSM_SEL_ZERO_RELOC);
    sel_reloc = (instr_i.selector == RSM_SEL_RELOC) ||
                (instr_i.selector == RSM_SEL_ZERO_RELOC);
    sel_known = sel_zero || sel_reloc || (instr_i.selector == RSM_SEL_PLAIN);
    // The immediate aa code cannot carry a relocated operand
    aa_imm = (instr_i.opcode[1:0] == RSM_AA_IMMEDIATE);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.res.reloc_we = 1'b0;
    st_nxt.res.pc_load = 1'b0;
    st_nxt.reloc_pend = 1'b0;
    st_nxt.jump_pend = 1'b0;

    case (st_r.state)
      RSM_ST_IDLE: begin
        if (start_i) begin
          st_nxt.res.illegal = 1'b0;
          if (is_shift) begin
            st_nxt.res.residue_flag = 1'b0;
            // Core carry is not a shifted-out one; zero count keeps it
            st_nxt.res.carry = (cnt_sel == CNT_NONE) ? carry_i : 1'b0;
            st_nxt.count = cnt_sel;
            st_nxt.arith = instr_i.opcode[1];
            case (instr_i.opcode)
              RSM_OP_ARITH_RIGHT_BYTE, RSM_OP_LOGIC_RIGHT_BYTE: begin
                st_nxt.size = SZ_BYTE;
                st_nxt.res.result = {24'h00_0000, instr_i.dest[7:0]};
                st_nxt.sign = instr_i.dest[7];
              end
              RSM_OP_ARITH_RIGHT_LONG, RSM_OP_LOGIC_RIGHT_LONG: begin
                st_nxt.size = SZ_LONG;
                st_nxt.res.result = instr_i.dest;
                st_nxt.sign = instr_i.dest[31];
              end
              default: begin
                st_nxt.size = SZ_WORD;
                st_nxt.res.result = {16'h0000, instr_i.dest[15:0]};
                st_nxt.sign = instr_i.dest[15];
              end
            endcase
            // Zero count goes straight to done, operand untouched
            st_nxt.state = (cnt_sel == CNT_NONE) ? RSM_ST_DONE : RSM_ST_SHIFT;
          end else if (is_mac) begin
            if (sel_reloc && aa_imm) begin
              st_nxt.res.illegal = 1'b1;
            end else begin
              if (sel_zero)
                st_nxt.res.product_sum_register = product_ext;
              else
                st_nxt.res.product_sum_register =
                  st_r.res.product_sum_register + product_ext;
              if (sel_reloc) begin
                // Strobe held back one cycle so it pulses with done
                st_nxt.reloc_pend = 1'b1;
                st_nxt.res.reloc_addr = instr_i.src_addr + RSM_RELOC_STEP;
                st_nxt.res.reloc_data = instr_i.src2;
              end
              st_nxt.res.illegal = !sel_known;
            end
            st_nxt.state = RSM_ST_DONE;
          end else if (is_jump) begin
            st_nxt.jump_pend = 1'b1;
            // Small mode wraps within the 64K page
            if (instr_i.big_mode)
              st_nxt.res.program_counter = instr_i.next_pc + disp_ext;
            else
              st_nxt.res.program_counter = {instr_i.next_pc[23:16],
                instr_i.next_pc[15:0] + disp_ext[15:0]};
            st_nxt.state = RSM_ST_DONE;
          end else begin
            // Skip and unknown codes: flags kept, second byte ignored
            st_nxt.res.illegal = (instr_i.opcode != RSM_OP_SKIP);
            st_nxt.state = RSM_ST_DONE;
          end
        end
      end
      RSM_ST_SHIFT: begin
        st_nxt.res.result = step_val;
        st_nxt.res.carry = step_carry;
        st_nxt.res.residue_flag = step_res;
        st_nxt.count = st_r.count - 5'h01;
        if (st_r.count == CNT_LAST)
          st_nxt.state = RSM_ST_DONE;
      end
      RSM_ST_DONE: begin
        st_nxt.done = 1'b1;
        // Strobes pulse with done so the core sees one event
        st_nxt.res.reloc_we = st_r.reloc_pend;
        st_nxt.res.pc_load = st_r.jump_pend;
        st_nxt.state = RSM_ST_IDLE;
      end
      default: st_nxt.state = RSM_ST_IDLE;
    endcase
    // Busy rises on the take edge and falls as done rises
    st_nxt.busy = (st_nxt.state != RSM_ST_IDLE);
  end

  // Reset clears every field, the outputs included
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
  assign done_o = st_r.done;
  assign res_o = st_r.res;
endmodule
`default_nettype wire

// ---- shared/rsm_pkg.sv ----
// Package for the right shift and signed multiply-accumulate unit
package rsm_pkg;
  // Opcodes
  localparam logic [7:0] RSM_OP_ARITH_RIGHT_BYTE = 8'h1A;
  localparam logic [7:0] RSM_OP_LOGIC_RIGHT_BYTE = 8'h18;
  localparam logic [7:0] RSM_OP_ARITH_RIGHT_WORD = 8'h0A;
  localparam logic [7:0] RSM_OP_LOGIC_RIGHT_WORD = 8'h08;
  localparam logic [7:0] RSM_OP_ARITH_RIGHT_LONG = 8'h0E;
  localparam logic [7:0] RSM_OP_LOGIC_RIGHT_LONG = 8'h0C;
  localparam logic [7:0] RSM_OP_SKIP = 8'h00;
  localparam logic [4:0] RSM_OP_SHORT_RELATIVE_JUMP_HI = 5'h04;
  localparam logic [5:0] RSM_OP_MAC2_HI = 6'h1B;
  localparam logic [5:0] RSM_OP_MAC3_HI = 6'h13;
  localparam logic [1:0] RSM_AA_IMMEDIATE = 2'h1;
  // Multiply-accumulate selector bytes
  localparam logic [7:0] RSM_SEL_PLAIN = 8'h01;
  localparam logic [7:0] RSM_SEL_RELOC = 8'h05;
  localparam logic [7:0] RSM_SEL_ZERO = 8'h09;
  localparam logic [7:0] RSM_SEL_ZERO_RELOC = 8'h0D;
  // Count limits, relocation step and accumulator width
  localparam logic [4:0] RSM_IMM_CNT_MASK = 5'h0F;
  localparam logic [4:0] RSM_REG_CNT_MASK = 5'h1F;
  localparam logic [7:0] RSM_REG_CNT_MIN = 8'h10;
  localparam logic [23:0] RSM_RELOC_STEP = 24'h00_0002;
  localparam int RSM_ACC_W = 40;

  typedef enum logic [1:0] {
    RSM_ST_IDLE = 2'b00,
    RSM_ST_SHIFT = 2'b01,
    RSM_ST_DONE = 2'b10
  } rsm_state_t;

  // Decoded instruction from the decoder
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] count_byte;
    logic count_is_reg;
    logic [7:0] count_reg_val;
    logic [31:0] dest;
    logic [15:0] src1;
    logic [15:0] src2;
    logic [7:0] selector;
    logic [23:0] src_addr;
    logic [10:0] disp;
    logic [23:0] next_pc;
    logic big_mode;
  } rsm_instr_t;

  // Results to the core
  typedef struct packed {
    logic [31:0] result;
    logic carry;
    logic residue_flag;
    logic [RSM_ACC_W-1:0] product_sum_register;
    logic reloc_we;
    logic [23:0] reloc_addr;
    logic [15:0] reloc_data;
    logic [23:0] program_counter;
    logic pc_load;
    logic illegal;
  } rsm_result_t;
endpackage

// ---- logic/rsm_shift_step.sv ----
// One right-shift step with carry and residue tracking
`timescale 1ns/100ps
`default_nettype none
module rsm_shift_step
  import rsm_pkg::*;
(
  // Operand state
  input wire logic [31:0] val_i,
  input wire logic [1:0] size_i,
  input wire logic arith_i,
  input wire logic sign_i,
  input wire logic carry_i,
  input wire logic residue_i,
  // Stepped state
  output logic [31:0] val_o,
  output logic carry_o,
  output logic residue_o
);
  logic [31:0] fill;
  always_comb begin
    fill = 32'h0000_0000;
    if (arith_i && sign_i) begin
      case (size_i)
        2'd0: fill = 32'h0000_0080;
        2'd1: fill = 32'h0000_8000;
        default: fill = 32'h8000_0000;
      endcase
    end
    val_o = (val_i >> 1) | fill;
    carry_o = val_i[0];
    // A one already in carry is folded into residue by this step
    residue_o = residue_i | carry_i;
  end
endmodule
`default_nettype wire

// ---- bench/rsm_unit_chk.sv ----
// Port assertions for the shift and multiply-accumulate unit
`timescale 1ns/100ps
`default_nettype none
module rsm_unit_chk
  import rsm_pkg::*;
(
  // Clock, reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Watched ports
  input wire logic start_i,
  input wire rsm_instr_t instr_i,
  input wire logic carry_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire rsm_result_t res_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic tk = start_i && !busy_o;
  wire logic [7:0] op = instr_i.opcode;
  wire logic c1 = tk && !instr_i.count_is_reg && instr_i.count_byte[3:0] == 4'h1;
  wire logic mac = tk && (op[7:2] == RSM_OP_MAC2_HI || op[7:2] == RSM_OP_MAC3_HI);
  wire logic signed [31:0] prod = $signed(instr_i.src1) * $signed(instr_i.src2);
  wire logic [39:0] pext = {{8{prod[31]}}, prod};
  wire logic [23:0] tgt = instr_i.next_pc + 24'($signed(instr_i.disp));
  zero_count_a: assert property (tk && op == RSM_OP_LOGIC_RIGHT_BYTE &&
    !instr_i.count_is_reg && instr_i.count_byte[3:0] == 4'h0 |-> ##2 done_o &&
    !res_o.residue_flag && res_o.result == {24'h00_0000, $past(instr_i.dest[7:0], 2)})
    else $error("zero count changed dest");
  one_step_a: assert property (c1 && op == RSM_OP_LOGIC_RIGHT_LONG |-> ##3 done_o &&
    res_o.result == {1'b0, $past(instr_i.dest[31:1], 3)} && !res_o.residue_flag &&
    res_o.carry == $past(instr_i.dest[0], 3)) else $error("logical step wrong");
  arith_step_a: assert property (c1 && op == RSM_OP_ARITH_RIGHT_LONG |-> ##3
    res_o.result == {$past(instr_i.dest[31], 3), $past(instr_i.dest[31:1], 3)})
    else $error("arith fill wrong");
  jump_a: assert property (tk && op[7:3] == RSM_OP_SHORT_RELATIVE_JUMP_HI && instr_i.big_mode |->
    ##2 res_o.pc_load && res_o.program_counter == $past(tgt, 2)) else $error("jump target wrong");
  skip_a: assert property (tk && op == RSM_OP_SKIP |-> ##2 done_o && !res_o.pc_load &&
    res_o.carry == $past(res_o.carry, 2) && res_o.residue_flag == $past(res_o.residue_flag, 2))
    else $error("skip changed state");
  reloc_a: assert property (mac && op[1:0] != RSM_AA_IMMEDIATE &&
    instr_i.selector == RSM_SEL_RELOC |-> ##2 res_o.reloc_we && res_o.reloc_data ==
    $past(instr_i.src2, 2) && res_o.reloc_addr == $past(instr_i.src_addr, 2) + RSM_RELOC_STEP)
    else $error("relocation wrong");
  reloc_imm_a: assert property (mac && op[1:0] == RSM_AA_IMMEDIATE && instr_i.selector[2]
    |-> ##2 done_o && res_o.illegal && !res_o.reloc_we) else $error("immediate reloc taken");
  zero_acc_a: assert property (mac && instr_i.selector == RSM_SEL_ZERO |-> ##2
    res_o.product_sum_register == $past(pext, 2)) else $error("zeroing mac wrong");
  plain_acc_a: assert property (mac && instr_i.selector == RSM_SEL_PLAIN |-> ##2
    res_o.product_sum_register == $past(res_o.product_sum_register, 2) + $past(pext, 2))
    else $error("accumulate wrong");
  shift_busy_a: assert property (c1 && op == RSM_OP_LOGIC_RIGHT_LONG |=>
    busy_o ##1 busy_o ##1 !busy_o && done_o) else $error("busy span wrong");
endmodule
bind rsm_unit rsm_unit_chk rsm_unit_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .start_i(start_i), .instr_i(instr_i), .carry_i(carry_i), .busy_o(busy_o),
  .done_o(done_o), .res_o(res_o));
`default_nettype wire

// ---- bench/rsm_unit_tb.sv ----
// Testbench for the shift and multiply-accumulate unit
`timescale 1ns/100ps
`default_nettype none
module rsm_unit_tb
  import rsm_pkg::*;
;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic carry_i = 1'b0;
  rsm_instr_t ins = '0;
  logic busy_o;
  logic done_o;
  rsm_result_t res_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [39:0] acc_m = '0;
  rsm_unit rsm_unit_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
    .instr_i(ins), .carry_i(carry_i), .busy_o(busy_o), .done_o(done_o), .res_o(res_o));
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Runs well under this; a hang ends the run
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Inputs change on the falling edge only
  task automatic go(input rsm_instr_t i, input logic c, output int lat);
    @(negedge mclk_i);
    ins = i;
    carry_i = c;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    lat = 0;
    do begin
      @(posedge mclk_i);
      #1;
      lat++;
    end while (done_o !== 1'b1 && lat < 40);
  endtask
  function automatic logic [33:0] ref_sh(logic [31:0] v, int w, bit ar, int n, logic c);
    logic st;
    logic sg;
    st = 1'b0;
    sg = v[w-1];
    for (int k = 0; k < n; k++) begin
      if (c && k > 0) st = 1'b1;
      c = v[0];
      v = v >> 1;
      v[w-1] = ar & sg;
    end
    return {st, c, v};
  endfunction
  task automatic t_shift();
    logic [7:0] ops[6] = '{RSM_OP_ARITH_RIGHT_BYTE, RSM_OP_LOGIC_RIGHT_BYTE,
      RSM_OP_ARITH_RIGHT_WORD, RSM_OP_LOGIC_RIGHT_WORD, RSM_OP_ARITH_RIGHT_LONG,
      RSM_OP_LOGIC_RIGHT_LONG};
    logic [8:0] cs[6] = '{9'h000, 9'h001, 9'h013, 9'h00F, 9'h11F, 9'h125};
    rsm_instr_t i;
    logic [33:0] e;
    int w;
    int n;
    int lat;
    for (int o = 0; o < 6; o++) begin
      for (int k = 0; k < 6; k++) begin
        w = ops[o][4] ? 8 : (ops[o][2] ? 32 : 16);
        n = cs[k][8] ? int'(cs[k][4:0]) : int'(cs[k][3:0]);
        i = '0;
        i.opcode = ops[o];
        i.count_is_reg = cs[k][8];
        i.count_byte = cs[k][8] ? 8'h10 : cs[k][7:0];
        i.count_reg_val = cs[k][7:0];
        i.dest = 32'h9A5C_BC81 & (w == 32 ? 32'hFFFF_FFFF : (32'h1 << w) - 32'h1);
        e = ref_sh(i.dest, w, ops[o][1], n, ~k[0]);
        go(i, ~k[0], lat);
        chk(res_o.result, e[31:0]);
        chk(res_o.carry, e[32]);
        chk(res_o.residue_flag, e[33]);
        chk(lat, n + 1);
      end
    end
    $display("shift test done");
  endtask
  task automatic t_mac();
    logic [7:0] sels[4] = '{RSM_SEL_PLAIN, RSM_SEL_RELOC, RSM_SEL_ZERO, RSM_SEL_ZERO_RELOC};
    rsm_instr_t i;
    logic [39:0] p;
    int lat;
    for (int s = 0; s < 8; s++) begin
      i = '0;
      i.opcode = {s[2] ? RSM_OP_MAC3_HI : RSM_OP_MAC2_HI, 2'h3};
      i.selector = sels[s[1:0]];
      i.src1 = 16'h8001 + 16'(s);
      i.src2 = 16'h7FF3;
      i.src_addr = 24'h00_FFFE;
      p = $signed(i.src1) * $signed(i.src2);
      acc_m = (i.selector[3] ? 40'h00_0000_0000 : acc_m) + p;
      go(i, 1'b0, lat);
      chk(res_o.product_sum_register, acc_m);
      chk(res_o.reloc_we, i.selector[2]);
      if (i.selector[2]) chk({res_o.reloc_addr, res_o.reloc_data}, {24'h01_0000, i.src2});
    end
    i.opcode = {RSM_OP_MAC3_HI, RSM_AA_IMMEDIATE};
    i.selector = RSM_SEL_RELOC;
    go(i, 1'b0, lat);
    chk({res_o.illegal, res_o.reloc_we}, 40'h00_0000_0002);
    $display("mac test done");
  endtask
  task automatic t_flow();
    rsm_instr_t i;
    logic [1:0] keep;
    int lat;
    i = '0;
    i.opcode = {RSM_OP_SHORT_RELATIVE_JUMP_HI, 3'h4};
    i.disp = 11'h400;
    i.next_pc = 24'h01_0010;
    i.big_mode = 1'b1;
    go(i, 1'b0, lat);
    chk({res_o.pc_load, res_o.program_counter}, {1'b1, 24'h00_FC10});
    i.opcode = {RSM_OP_SHORT_RELATIVE_JUMP_HI, 3'h3};
    i.disp = 11'h3FF;
    i.next_pc = 24'h00_FE00;
    i.big_mode = 1'b0;
    go(i, 1'b0, lat);
    chk({res_o.pc_load, res_o.program_counter[15:0]}, {1'b1, 16'h01FF});
    keep = {res_o.carry, res_o.residue_flag};
    i = '0;
    i.count_byte = 8'hA5;
    go(i, ~keep[1], lat);
    chk({lat[7:0], res_o.pc_load, res_o.carry, res_o.residue_flag}, {8'h01, 1'b0, keep});
    $display("flow test done");
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_mac();
    t_shift();
    t_flow();
    close_out();
  end
endmodule
`default_nettype wire
